// file: sra_pkg.sv
// Constants shared by the serial register access slave.
package sra_pkg;

	localparam int DGRAM_BITS  = 40;
	localparam int STATUS_BITS = 8;
	localparam int ADDR_BITS   = 7;
	localparam int DATA_BITS   = 32;
	localparam int WRITE_POS   = 39;
	localparam int ADDR_MSB    = 38;
	localparam int ADDR_LSB    = 32;
	localparam int COUNT_BITS  = 6;
	localparam int SYNC_WIDTH  = 3;

	localparam logic [COUNT_BITS-1:0] COUNT_FULL  = 6'h28;
	localparam logic [COUNT_BITS-1:0] COUNT_RESET = 6'h00;
	localparam logic [DATA_BITS-1:0]  RESP_RESET  = 32'h0000_0000;
	localparam logic [ADDR_BITS-1:0]  ADDR_RESET  = 7'h00;
	// Select idles high, clock and data low, so reset starts no false frame.
	localparam logic [SYNC_WIDTH-1:0] SYNC_RESET  = 3'h4;

	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'h1,
		ST_XFER  = 3'h2,
		ST_FETCH = 3'h4
	} sra_state_e;

endpackage

// file: sra_sync.sv
// Two flip-flop synchroniser, one chain per bit.
module sra_sync
(
	input  wire logic                          core_clk,
	input  wire logic                          reset,
	input  wire logic [sra_pkg::SYNC_WIDTH-1:0] async_in,
	output logic      [sra_pkg::SYNC_WIDTH-1:0] sync_out
);

	logic [sra_pkg::SYNC_WIDTH-1:0] meta_reg;
	logic [sra_pkg::SYNC_WIDTH-1:0] sync_reg;

	genvar i;
	generate
		for (i = 0; i < sra_pkg::SYNC_WIDTH; i++)
		begin : g_bit
			always_ff @(posedge core_clk or posedge reset)
			begin
				if (reset)
				begin
					meta_reg[i] <= sra_pkg::SYNC_RESET[i];
					sync_reg[i] <= sra_pkg::SYNC_RESET[i];
				end
				else
				begin
					meta_reg[i] <= async_in[i];
					sync_reg[i] <= meta_reg[i];
				end
			end
		end
	endgenerate

	assign sync_out = sync_reg;

endmodule

// file: sra_spi_slave.sv
// Serial register access slave with 40-bit datagrams.
// How it works
// - A transaction of forty bits or more executes one forty-bit datagram.
// - One bit is shifted out for every bit shifted in.
// - Datagram is one address byte then four data bytes.
// - Every access moves a full 32 data bits.
// - Bit 39 is the write flag, next seven bits the address.
// - Response data is shifted out in every datagram.
// - After a read, response data is the register read.
// - After a write, response data echoes the written word.
// - Read data bits are dummies and never write the register.
// - Read data is latched right after the read is accepted.
// - The first eight bits returned are the status byte.
// - Sample on rising clock, drive after falling, MSB first.
// - Bits beyond forty reappear on the output forty clocks later.
// - Only the last forty bits execute; shorter datagrams are dropped.
module sra_spi_slave
(
	input  wire logic                           core_clk,
	input  wire logic                           reset,
	input  wire logic                           host_select_n,
	input  wire logic                           host_serial_clock,
	input  wire logic                           host_serial_in,
	output logic                                host_serial_out,
	output logic                                host_serial_out_oe_n,
	input  wire logic [sra_pkg::STATUS_BITS-1:0] status_flags,
	output logic                                reg_read_strobe,
	output logic      [sra_pkg::ADDR_BITS-1:0]   reg_read_addr,
	input  wire logic [sra_pkg::DATA_BITS-1:0]   reg_read_data,
	output logic                                reg_write_strobe,
	output logic      [sra_pkg::ADDR_BITS-1:0]   reg_write_addr,
	output logic      [sra_pkg::DATA_BITS-1:0]   reg_write_data
);

	logic [sra_pkg::SYNC_WIDTH-1:0]  pins_sync;
	logic                            sel_n_s;
	logic                            sclk_s;
	logic                            sdi_s;
	logic                            sclk_prev_reg;
	logic                            sclk_prev_next;
	logic                            sclk_rise;
	logic                            sclk_fall;

	sra_pkg::sra_state_e             state_reg;
	sra_pkg::sra_state_e             state_next;
	logic [sra_pkg::DGRAM_BITS-1:0]  shift_reg;
	logic [sra_pkg::DGRAM_BITS-1:0]  shift_next;
	logic [sra_pkg::COUNT_BITS-1:0]  count_reg;
	logic [sra_pkg::COUNT_BITS-1:0]  count_next;
	logic [sra_pkg::DATA_BITS-1:0]   resp_reg;
	logic [sra_pkg::DATA_BITS-1:0]   resp_next;
	logic                            sdo_reg;
	logic                            sdo_next;
	logic                            oe_n_reg;
	logic                            oe_n_next;
	logic [sra_pkg::ADDR_BITS-1:0]   raddr_reg;
	logic [sra_pkg::ADDR_BITS-1:0]   raddr_next;
	logic                            wstb_reg;
	logic                            wstb_next;
	logic [sra_pkg::ADDR_BITS-1:0]   waddr_reg;
	logic [sra_pkg::ADDR_BITS-1:0]   waddr_next;
	logic [sra_pkg::DATA_BITS-1:0]   wdata_reg;
	logic [sra_pkg::DATA_BITS-1:0]   wdata_next;

	// The link clock is sampled like any pin, so its rate must stay at
	// or below a quarter of core_clk for both edges to be seen.
	sra_sync u_sync
	(
		.core_clk (core_clk),
		.reset    (reset),
		.async_in ({host_select_n, host_serial_clock, host_serial_in}),
		.sync_out (pins_sync)
	);

	assign sel_n_s   = pins_sync[2];
	assign sclk_s    = pins_sync[1];
	assign sdi_s     = pins_sync[0];
	assign sclk_rise = sclk_s & ~sclk_prev_reg;
	assign sclk_fall = ~sclk_s & sclk_prev_reg;

	always_comb
	begin
		state_next = state_reg;
		shift_next = shift_reg;
		count_next = count_reg;
		resp_next  = resp_reg;
		sdo_next   = sdo_reg;
		oe_n_next  = oe_n_reg;
		raddr_next = raddr_reg;
		wstb_next  = 1'b0;
		waddr_next = waddr_reg;
		wdata_next = wdata_reg;
		case (state_reg)
			sra_pkg::ST_IDLE:
			begin
				oe_n_next = 1'b1;
				if (!sel_n_s)
				begin
					// Status leads, then the pipelined response word.
					shift_next = {status_flags, resp_reg};
					sdo_next   = status_flags[sra_pkg::STATUS_BITS-1];
					oe_n_next  = 1'b0;
					count_next = sra_pkg::COUNT_RESET;
					state_next = sra_pkg::ST_XFER;
				end
			end
			sra_pkg::ST_XFER:
			begin
				if (sel_n_s)
				begin
					oe_n_next  = 1'b1;
					state_next = sra_pkg::ST_IDLE;
					// The last forty bits in the register form the command.
					if (count_reg == sra_pkg::COUNT_FULL)
					begin
						if (shift_reg[sra_pkg::WRITE_POS])
						begin
							wstb_next  = 1'b1;
							waddr_next = shift_reg[sra_pkg::ADDR_MSB:
								sra_pkg::ADDR_LSB];
							wdata_next = shift_reg[sra_pkg::DATA_BITS-1:0];
							resp_next  = shift_reg[sra_pkg::DATA_BITS-1:0];
						end
						else
						begin
							// Read data bits are dropped here.
							raddr_next = shift_reg[sra_pkg::ADDR_MSB:
								sra_pkg::ADDR_LSB];
							state_next = sra_pkg::ST_FETCH;
						end
					end
				end
				else
				begin
					if (sclk_rise)
					begin
						// Shifting through keeps extra bits flowing out
						// forty clocks later for daisy chains.
						shift_next = {shift_reg[sra_pkg::DGRAM_BITS-2:0],
							sdi_s};
						if (count_reg != sra_pkg::COUNT_FULL)
						begin
							count_next = count_reg + 6'h01;
						end
					end
					if (sclk_fall)
					begin
						sdo_next = shift_reg[sra_pkg::DGRAM_BITS-1];
					end
				end
			end
			sra_pkg::ST_FETCH:
			begin
				// Capture once, so later register changes cannot leak in.
				resp_next  = reg_read_data;
				state_next = sra_pkg::ST_IDLE;
			end
			default:
			begin
				oe_n_next  = 1'b1;
				state_next = sra_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			state_reg     <= sra_pkg::ST_IDLE;
			shift_reg     <= {sra_pkg::DGRAM_BITS{1'b0}};
			count_reg     <= sra_pkg::COUNT_RESET;
			resp_reg      <= sra_pkg::RESP_RESET;
			sdo_reg       <= 1'b0;
			oe_n_reg      <= 1'b1;
			raddr_reg     <= sra_pkg::ADDR_RESET;
			wstb_reg      <= 1'b0;
			waddr_reg     <= sra_pkg::ADDR_RESET;
			wdata_reg     <= sra_pkg::RESP_RESET;
		end
		else
		begin
			state_reg     <= state_next;
			shift_reg     <= shift_next;
			count_reg     <= count_next;
			resp_reg      <= resp_next;
			sdo_reg       <= sdo_next;
			oe_n_reg      <= oe_n_next;
			raddr_reg     <= raddr_next;
			wstb_reg      <= wstb_next;
			waddr_reg     <= waddr_next;
			wdata_reg     <= wdata_next;
		end
	end

	// The previous link clock sample resets to the idle low level of the
	// pin, so no false edge follows reset.
	always_comb
	begin
		sclk_prev_next = sclk_s;
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			sclk_prev_reg <= 1'b0;
		end
		else
		begin
			sclk_prev_reg <= sclk_prev_next;
		end
	end

	assign host_serial_out      = sdo_reg;
	assign host_serial_out_oe_n = oe_n_reg;
	assign reg_read_strobe      = (state_reg == sra_pkg::ST_FETCH);
	assign reg_read_addr        = raddr_reg;
	assign reg_write_strobe     = wstb_reg;
	assign reg_write_addr       = waddr_reg;
	assign reg_write_data       = wdata_reg;

endmodule

// file: sra_spi_slave_properties.sv
// Port checks for the serial register access slave.
module sra_props
(
	input wire logic	core_clk,
	input wire logic	reset,
	input wire logic	host_select_n,
	input wire logic	host_serial_clock,
	input wire logic	host_serial_in,
	input wire logic	host_serial_out,
	input wire logic	host_serial_out_oe_n,
	input wire logic [sra_pkg::STATUS_BITS-1:0]	status_flags,
	input wire logic	reg_read_strobe,
	input wire logic [sra_pkg::ADDR_BITS-1:0]	reg_read_addr,
	input wire logic [sra_pkg::DATA_BITS-1:0]	reg_read_data,
	input wire logic	reg_write_strobe,
	input wire logic [sra_pkg::ADDR_BITS-1:0]	reg_write_addr,
	input wire logic [sra_pkg::DATA_BITS-1:0]	reg_write_data
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff reset;
	AST_ONE_STROBE: assert property (!(reg_read_strobe && reg_write_strobe))
		else $error("read and write strobes together");
	AST_WR_PULSE: assert property (reg_write_strobe |=> !reg_write_strobe)
		else $error("write strobe too long");
	AST_RD_PULSE: assert property (reg_read_strobe |=> !reg_read_strobe)
		else $error("read strobe too long");
	AST_EXEC_SEL: assert property ((reg_read_strobe || reg_write_strobe)
		|-> host_select_n && $past(host_select_n, 2))
		else $error("access executed while selected");
	AST_EXEC_REL: assert property ((reg_read_strobe || reg_write_strobe)
		|-> host_serial_out_oe_n)
		else $error("output driven at execution");
	AST_OE_OFF: assert property (host_select_n [*5] |-> host_serial_out_oe_n)
		else $error("output not released");
	AST_OE_ON: assert property (!host_select_n [*6] |-> !host_serial_out_oe_n)
		else $error("output not driven in frame");
	AST_WR_HOLD: assert property ($changed({reg_write_addr, reg_write_data})
		|-> reg_write_strobe)
		else $error("write word moved without strobe");
	cover property (reg_write_strobe);
	cover property (reg_read_strobe);
	cover property ($fell(host_serial_out_oe_n));
endmodule

bind sra_spi_slave sra_props u_props (.*);

// file: sra_host_model.sv
// Host side model that masters the serial link.
module sra_host_model
(
	output logic	host_select_n,
	output logic	host_serial_clock,
	output logic	host_serial_in,
	input wire logic	sdo
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		host_select_n = 1'b1;
		host_serial_clock = 1'b0;
		host_serial_in = 1'b0;
	end
	// The clock stands low between frames; a 32 ns period keeps it under core/4.
	task automatic xfer(input int n, input logic [79:0] tx,
		output logic [79:0] rx);
		rx = 'x;
		host_select_n = 1'b0;
		#40;
		for (int i = n - 1; i >= 0; i--)
		begin
			host_serial_in = tx[i];
			#16 host_serial_clock = 1'b1;
			// Sampled late in the high phase, well after the falling-edge update.
			#14 rx = {rx[78:0], sdo};
			#2 host_serial_clock = 1'b0;
		end
		#20 host_select_n = 1'b1;
		host_serial_in = ~host_serial_in;
		#40;
	endtask
endmodule

// file: testbench.sv
// Self-checking bench for the serial register access slave.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [39:0] tx; logic [7:0] st; logic [31:0] ed;} sra_row_s;
	logic	core_clk, reset, host_select_n, host_serial_clock, host_serial_in;
	logic	host_serial_out, host_serial_out_oe_n, reg_read_strobe, reg_write_strobe;
	logic [7:0]	status_flags;
	logic [6:0]	reg_read_addr, reg_write_addr;
	logic [31:0]	reg_read_data, reg_write_data;
	logic [31:0]	regs [128];
	logic [79:0]	rx;
	int	err_count = 0, num_checks = 0, cycles = 0, writes = 0;
	sra_row_s	rows [6] = '{
		'{40'h21_0000_0000, 8'hA5, 32'h0000_0000},
		'{40'h21_FFFF_FFFF, 8'h5A, 32'hCAFE_0021},
		'{40'hA2_00AB_CDEF, 8'hC3, 32'hCAFE_0021},
		'{40'hA2_0012_3456, 8'h3C, 32'h00AB_CDEF},
		'{40'h22_0000_0000, 8'h0F, 32'h0012_3456},
		'{40'h00_0000_0000, 8'hF0, 32'h0012_3456}};
	sra_spi_slave uut (.*);
	sra_host_model host (.host_select_n, .host_serial_clock, .host_serial_in,
		.sdo(host_serial_out_oe_n ? 1'bz : host_serial_out));
	assign reg_read_data = regs[reg_read_addr];
	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [47:0] seen,
		input logic [47:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic run(input int n, input logic [79:0] tx, input logic [7:0] st);
		@(posedge core_clk);
		#1 status_flags = st;
		host.xfer(n, tx, rx);
	endtask
	// Select must not look active just after reset, or a false frame runs.
	task automatic do_reset;
		reset = 1'b1;
		repeat (6) @(posedge core_clk);
		#1 reset = 1'b0;
		chk("oe_n", host_serial_out_oe_n, 1'b1);
		chk("strobes", {reg_read_strobe, reg_write_strobe}, 2'b00);
		repeat (2) @(posedge core_clk);
		#1;
		chk("oe_n2", host_serial_out_oe_n, 1'b1);
		chk("strobes2", {reg_read_strobe, reg_write_strobe}, 2'b00);
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cycles++;
		if (reg_write_strobe === 1'b1)
		begin
			regs[reg_write_addr] <= reg_write_data;
			writes++;
		end
		// A whole run needs about 3600 cycles.
		if (cycles == 10000)
		begin
			err_count++;
			close_out;
		end
	end
	initial
	begin
		reset = 1'b1;
		status_flags = 8'h00;
		for (int i = 0; i < 128; i++)
			regs[i] = 32'hCAFE_0000 + i;
		do_reset;
		foreach (rows[i])
		begin
			run(40, rows[i].tx, rows[i].st);
			chk("row", rx[39:0], {rows[i].st, rows[i].ed});
		end
		run(8, 80'h21, 8'h81);
		chk("short", rx[7:0], 8'h81);
		// The long frame also proves the short one changed nothing.
		run(48, {8'hEE, 40'hA2_0000_BEEF}, 8'h42);
		chk("long", rx[47:0], {8'h42, 32'hCAFE_0000, 8'hEE});
		chk("waddr", reg_write_addr, 7'h22);
		chk("wdata", reg_write_data, 32'h0000_BEEF);
		run(40, 40'h21_0000_0000, 8'h24);
		chk("echo", rx[39:0], {8'h24, 32'h0000_BEEF});
		chk("raddr", reg_read_addr, 7'h21);
		regs[7'h21] = 32'h0000_0000;
		run(40, 40'h00_0000_0000, 8'h18);
		chk("latched", rx[31:0], 32'hCAFE_0021);
		chk("reg", regs[7'h22], 32'h0000_BEEF);
		chk("writes", writes, 3);
		// A reset between frames must clear the pipelined response word.
		do_reset;
		run(40, 40'h21_0000_0000, 8'h66);
		chk("after_reset", rx[39:0], {8'h66, sra_pkg::RESP_RESET});
		close_out;
	end
endmodule
